//--- dv/dsbp_stage_model.sv
// power transistor stage as seen at the sense and overcurrent pins
`timescale 1ns/1ps

module dsbp_stage_model (
  // from the driver
  input wire logic gateOn,
  input wire logic satSenseOe,
  input wire logic satSenseOut,
  // fault injection
  input wire logic desatFault,
  input wire logic shortCircuit,
  // to the driver
  output logic satSenseIn,
  output logic overcurrentSense
);
  // internal pull-up lifts the pin unless the driver sinks it;
  // a saturated transistor keeps it low while on
  assign satSenseIn = satSenseOe ? satSenseOut : (gateOn ? desatFault : 1'b1);
  assign overcurrentSense = gateOn & shortCircuit;
endmodule

//--- dv/testbench.sv
// self-checking bench of the protection sequencer
`timescale 1ns/1ps
`include "dsbp_cfg.svh"
`define CHK(nm, e, a) begin total_checks++; if ((a) !== (e)) begin bad_count++; \
  $display("ERROR %s expected %0h seen %0h", nm, e, a); end end

module testbench;
  import dsbp_pkg::*;
  // ==========================================================
  // signals and case table
  localparam int WDOG = 400;
  localparam int ACL = `DSBP_ACLD_CYC;
  localparam int CE = 0, FR = 1, RI = 2, EB = 3, EC = 4;
  typedef struct {
    dsbp_time_t b, ocb, pl;
    logic sat, oc;
    int on, eb, eo, ea;
  } dsbp_row_t;
  // blank, oc blank, plateau, faults, on time, expected blank/pulldown/clamp delay
  dsbp_row_t rows [6] = '{
    '{8'h08, 8'h04, 8'h03, 1'b0, 1'b0, 40, 8, 11, ACL},
    '{8'h40, 8'h04, 8'h05, 1'b0, 1'b0, 100, 64, 5, ACL},
    '{8'h3f, 8'h04, 8'h02, 1'b0, 1'b0, 100, 63, 65, ACL},
    '{8'h0a, 8'h04, 8'h04, 1'b1, 1'b0, 40, 10, 14, 0},
    '{8'h14, 8'h06, 8'h03, 1'b0, 1'b1, 40, 0, 23, 0},
    '{8'h28, 8'h1e, 8'h03, 1'b0, 1'b1, 25, 0, 43, ACL}
  };
  int bad_count = 0;
  int total_checks = 0;
  int bCnt, oCnt, aCnt, pCnt;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic pwmIn = 1'b0, desatFault = 1'b0, shortCircuit = 1'b0, selReq = 1'b0, refReq = 1'b0;
  logic clampEn = 1'b0;
  logic [4:0] ctl = 5'h00;
  dsbp_time_t blankA = 8'h08, blankB = 8'h0c, ocBlank = 8'h04, plat = 8'h03;
  logic gateOn, tlto, acld, senseOut, senseOe, fault_n, cmpStat, satErr, ocErr, toErr;
  logic selStat, selPrim, selMir, refMir, notify, disabled, senseIn, ocSense;

  always #12.5 clock = ~clock;

  dsbp_protect #(.WDOG_CYCLES(WDOG)) i_dut (
    .clock(clock), .reset_n(reset_n), .pwmIn(pwmIn), .satSenseIn(senseIn),
    .overcurrentSense(ocSense), .blankSelectRequest(selReq), .blankRefreshRequest(refReq),
    .blankingTimeRegA(blankA), .blankingTimeRegB(blankB), .overcurrentBlankingReg(ocBlank),
    .twoLevelTurnoffTime(plat), .turnoffClampEnable(clampEn), .clearErrors(ctl[CE]),
    .fastReactivate(ctl[FR]), .fullReinit(ctl[RI]), .catBEvent(ctl[EB]), .catCEvent(ctl[EC]),
    .gateOn(gateOn), .twoLevelTurnoff(tlto), .activeClampDelay(acld),
    .satSenseOut(senseOut), .satSenseOe(senseOe), .fastFaultOut_n(fault_n),
    .satComparatorStatus(cmpStat), .satErrorFlag(satErr), .overcurrentErrorFlag(ocErr),
    .blankTimeoutError(toErr), .blankSelectStatus(selStat),
    .blankSelectMirrorPrimary(selPrim), .blankSelectMirror(selMir),
    .blankRefreshMirror(refMir), .notifyFlag(notify), .deviceDisabled(disabled)
  );

  dsbp_stage_model i_stage (
    .gateOn(gateOn), .satSenseOe(senseOe), .satSenseOut(senseOut), .desatFault(desatFault),
    .shortCircuit(shortCircuit), .satSenseIn(senseIn), .overcurrentSense(ocSense)
  );

  // ==========================================================
  // tasks
  task automatic cycles(input int n);
    repeat (n) @(posedge clock);
    @(negedge clock);
  endtask

  task automatic pulse(input int k);
    @(posedge clock);
    ctl[k] <= 1'b1;
    repeat (2) @(posedge clock);
    ctl[k] <= 1'b0;
    cycles(5);
  endtask

  // one on command, then measures the whole turn-off
  task automatic run_pulse(input int onCyc);
    bCnt = 0;
    oCnt = 0;
    aCnt = 0;
    pCnt = 0;
    for (int i = 0; i < 250; i++) begin
      @(posedge clock);
      pwmIn <= (i < onCyc);
      @(negedge clock);
      bCnt += ((gateOn & senseOe) === 1'b1);
      oCnt += ((~gateOn & senseOe & ~acld) === 1'b1);
      aCnt += (acld === 1'b1);
      pCnt += (tlto === 1'b1);
    end
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // ==========================================================
  // sequence
  initial begin
    repeat (4) @(posedge clock);
    reset_n <= 1'b1;
    cycles(5);
    `CHK("gateOn", 1'b0, gateOn)
    `CHK("fault_n", 1'b1, fault_n)
    `CHK("selStat", 1'b0, selStat)
    `CHK("cmpStat", 1'b1, cmpStat)
    `CHK("satErr", 1'b0, satErr)
    @(posedge clock);
    clampEn <= 1'b1;
    cycles(5);
    `CHK("senseOe", 1'b1, senseOe)
    `CHK("cmpStat", 1'b0, cmpStat)
    `CHK("senseOut", 1'b0, senseOut)
    @(posedge clock);
    clampEn <= 1'b0;
    foreach (rows[k]) begin
      @(posedge clock);
      blankA <= rows[k].b;
      ocBlank <= rows[k].ocb;
      plat <= rows[k].pl;
      desatFault <= rows[k].sat;
      shortCircuit <= rows[k].oc;
      run_pulse(rows[k].on);
      if (rows[k].eb != 0) `CHK("blank", rows[k].eb, bCnt)
      `CHK("pulldown", rows[k].eo, oCnt)
      `CHK("clampDelay", rows[k].ea, aCnt)
      `CHK("satErr", rows[k].sat, satErr)
      `CHK("ocErr", rows[k].oc & (rows[k].ea == 0), ocErr)
      `CHK("fault_n", ~(rows[k].sat | (rows[k].ea == 0)), fault_n)
      `CHK("disabled", rows[k].ea == 0, disabled)
      `CHK("plateau", rows[k].pl, pCnt)
      @(posedge clock);
      desatFault <= 1'b0;
      shortCircuit <= 1'b0;
      pulse(RI);
    end
    // class A fault: reactivation leaves the flag latched
    @(posedge clock);
    blankA <= 8'h0a;
    ocBlank <= 8'h04;
    desatFault <= 1'b1;
    run_pulse(40);
    @(posedge clock);
    desatFault <= 1'b0;
    pulse(FR);
    `CHK("disabled", 1'b0, disabled)
    `CHK("satErr", 1'b1, satErr)
    pulse(CE);
    `CHK("satErr", 1'b0, satErr)
    `CHK("fault_n", 1'b1, fault_n)
    pulse(EB);
    pulse(FR);
    `CHK("disabled", 1'b1, disabled)
    run_pulse(30);
    `CHK("blockedOn", 0, bCnt)
    pulse(RI);
    `CHK("disabled", 1'b0, disabled)
    @(posedge clock);
    pwmIn <= 1'b1;
    cycles(20);
    pulse(EC);
    `CHK("notify", 1'b1, notify)
    `CHK("gateOn", 1'b1, gateOn)
    `CHK("disabled", 1'b0, disabled)
    // class B event while on: output stage must drop on its own
    pulse(EB);
    `CHK("gateOn", 1'b0, gateOn)
    `CHK("disabled", 1'b1, disabled)
    @(posedge clock);
    pwmIn <= 1'b0;
    pulse(RI);
    // select alone must not switch; host bits are level requests
    @(posedge clock);
    selReq <= 1'b1;
    cycles(6);
    `CHK("selStat", 1'b0, selStat)
    @(posedge clock);
    refReq <= 1'b1;
    cycles(6);
    `CHK("selMir", 1'b1, selMir)
    `CHK("refMir", 1'b1, refMir)
    `CHK("selStat", 1'b1, selStat)
    `CHK("selPrim", 1'b1, selPrim)
    run_pulse(40);
    `CHK("blankB", 12, bCnt)
    cycles(100);
    `CHK("selStat", 1'b1, selStat)
    @(posedge clock);
    refReq <= 1'b0;
    repeat (6) @(posedge clock);
    refReq <= 1'b1;
    cycles(380);
    `CHK("selStat", 1'b1, selStat)
    cycles(40);
    `CHK("selStat", 1'b0, selStat)
    `CHK("selPrim", 1'b0, selPrim)
    `CHK("toErr", 1'b1, toErr)
    `CHK("notify", 1'b1, notify)
    `CHK("disabled", 1'b0, disabled)
    @(posedge clock);
    refReq <= 1'b0;
    repeat (6) @(posedge clock);
    refReq <= 1'b1;
    cycles(6);
    `CHK("selStat", 1'b1, selStat)
    @(posedge clock);
    selReq <= 1'b0;
    cycles(6);
    `CHK("selStat", 1'b0, selStat)
    `CHK("selMir", 1'b0, selMir)
    tally_and_finish();
  end
endmodule

//--- logic/dsbp_cfg.svh
// constants of the saturation and overcurrent protection block
`ifndef DSBP_CFG_SVH
`define DSBP_CFG_SVH

// ==========================================================
// clock
`define DSBP_CLK_MHZ 40

// ==========================================================
// timing
`define DSBP_ACLD_TIME_NS 500
`define DSBP_ACLD_CYC ((`DSBP_ACLD_TIME_NS * `DSBP_CLK_MHZ + 999) / 1000)
`define DSBP_WDOG_TIME_US 1000
`define DSBP_WDOG_CYC (`DSBP_WDOG_TIME_US * `DSBP_CLK_MHZ)
`define DSBP_WDOG_W 20

// ==========================================================
// fields and limits
`define DSBP_TIME_W 8
`define DSBP_EXT_LIMIT 8'h40

// ==========================================================
// reset values
`define DSBP_RST_FLAG 1'b0
`define DSBP_RST_CNT 8'h00
`define DSBP_RST_WDOG 20'h00000

`endif

//--- logic/dsbp_pkg.sv
// types of the saturation and overcurrent protection block
`include "dsbp_cfg.svh"

package dsbp_pkg;

  // ==========================================================
  // sequencer states
  typedef enum logic [5:0] {
    ST_OFF   = 6'b000001,
    ST_BLANK = 6'b000010,
    ST_ON    = 6'b000100,
    ST_ACLD  = 6'b001000,
    ST_PLAT  = 6'b010000,
    ST_HARD  = 6'b100000
  } dsbp_state_t;

  typedef logic [`DSBP_TIME_W-1:0] dsbp_time_t;

  // ==========================================================
  // whole block state
  typedef struct packed {
    dsbp_state_t st;
    dsbp_time_t cnt;
    dsbp_time_t ocCnt;
    logic [`DSBP_WDOG_W-1:0] wdog;
    logic [4:0] sync1;
    logic [4:0] sync2;
    logic selMirror;
    logic refMirror;
    logic selStatus;
    logic toBlock;
    logic satErr;
    logic ocErr;
    logic toErr;
    logic notifyC;
    logic disA;
    logic disB;
    logic safeOff;
  } dsbp_regs_t;

endpackage

//--- logic/dsbp_protect.sv
// saturation, overcurrent and blanking selection protection sequencer
//
// What this block does
// RL1 - class A fault disables until fast reactivation
// RL2 - class B event disables until full reinitialisation
// RL3 - class C events only notify, never disable
// RL4 - comparator result readable as status bit
// RL5 - sense pin held low for blanking at turn-on
// RL6 - saturation after blanking: safe off, flag, fault
// RL7 - saturation checked only while on commanded
// RL8 - turn-off pulldown: plateau, plus blanking below 0x40
// RL9 - clamp enable pulls sense low while off
// RL10 - safe-off sequences skip active clamp delay
// RL11 - select status picks blanking register A or B
// RL12 - selection shown locally and mirrored to primary
// RL13 - host select/refresh mirrored into secondary bits
// RL14 - selection sets only with select and refresh
// RL15 - selection clears on select low or timeout
// RL16 - selection rise restarts watchdog, counts while set
// RL17 - refresh rise restarts watchdog; host must refresh
// RL18 - watchdog overflow: revert to A, timeout flag
// RL19 - overcurrent monitored while on: safe off, flag
// RL20 - overcurrent blanked at turn-on, idle while off
// RL21 - software keeps overcurrent blanking below saturation's
// RL22 - error flags sticky until software clears them
`timescale 1ns/1ps
`include "dsbp_cfg.svh"

module dsbp_protect #(
  parameter int WDOG_CYCLES = `DSBP_WDOG_CYC
) (
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // pins and primary-side requests, asynchronous
  input wire logic pwmIn,
  input wire logic satSenseIn,
  input wire logic overcurrentSense,
  input wire logic blankSelectRequest,
  input wire logic blankRefreshRequest,
  // configuration
  input wire dsbp_pkg::dsbp_time_t blankingTimeRegA,
  input wire dsbp_pkg::dsbp_time_t blankingTimeRegB,
  input wire dsbp_pkg::dsbp_time_t overcurrentBlankingReg,
  input wire dsbp_pkg::dsbp_time_t twoLevelTurnoffTime,
  input wire logic turnoffClampEnable,
  // control pulses and other fault classes
  input wire logic clearErrors,
  input wire logic fastReactivate,
  input wire logic fullReinit,
  input wire logic catBEvent,
  input wire logic catCEvent,
  // output stage and sense pin
  output logic gateOn,
  output logic twoLevelTurnoff,
  output logic activeClampDelay,
  output logic satSenseOut,
  output logic satSenseOe,
  // status
  output logic fastFaultOut_n,
  output logic satComparatorStatus,
  output logic satErrorFlag,
  output logic overcurrentErrorFlag,
  output logic blankTimeoutError,
  output logic blankSelectStatus,
  output logic blankSelectMirrorPrimary,
  output logic blankSelectMirror,
  output logic blankRefreshMirror,
  output logic notifyFlag,
  output logic deviceDisabled
);
  import dsbp_pkg::*;

  dsbp_regs_t q;
  dsbp_regs_t d;

  // ==========================================================
  // decoded helpers
  logic pwmS;
  logic satS;
  logic ocS;
  logic onCmd;
  logic refRise;
  logic wdogOver;
  logic satFault;
  logic ocFault;
  dsbp_time_t blankActive;

  function automatic logic reached(input dsbp_time_t c, input dsbp_time_t lim);
    reached = ({1'b0, c} + 9'h001) >= {1'b0, lim};
  endfunction

  assign pwmS = q.sync2[0];
  assign satS = q.sync2[1];
  assign ocS = q.sync2[2];
  assign onCmd = pwmS & ~q.disA & ~q.disB;
  assign refRise = q.sync2[4] & ~q.refMirror;
  assign blankActive = q.selStatus ? blankingTimeRegB : blankingTimeRegA; // RL11
  assign wdogOver = q.selStatus && (q.wdog == `DSBP_WDOG_W'(WDOG_CYCLES - 1));
  // saturation looked at only after blanking while on is commanded
  assign satFault = (q.st == ST_ON) & satS; // RL6 RL7
  // overcurrent blanking runs from turn-on, independent of the other one
  assign ocFault = ((q.st == ST_BLANK) | (q.st == ST_ON)) & ocS
                   & reached(q.ocCnt, overcurrentBlankingReg); // RL19 RL20

  // ==========================================================
  // next state
  always_comb begin
    d = q;
    d.sync1 = {blankRefreshRequest, blankSelectRequest, overcurrentSense, satSenseIn, pwmIn};
    d.sync2 = q.sync1;
    d.selMirror = q.sync2[3]; // RL13
    d.refMirror = q.sync2[4]; // RL13
    d.cnt = q.cnt + 8'h01;

    // blanking register selection and its watchdog
    if (!q.selMirror) begin
      d.selStatus = 1'b0; // RL15
    end else if (wdogOver) begin
      d.selStatus = 1'b0; // RL15 RL18
      d.toBlock = 1'b1;
    end else if (q.refMirror && !q.toBlock) begin
      d.selStatus = 1'b1; // RL14
    end
    // a timeout holds until a new refresh edge, else it would re-arm at once
    if (!q.refMirror) begin
      d.toBlock = 1'b0;
    end
    if ((d.selStatus && !q.selStatus) || refRise) begin
      d.wdog = `DSBP_RST_WDOG; // RL16 RL17
    end else if (q.selStatus) begin
      d.wdog = q.wdog + `DSBP_WDOG_W'(1); // RL16
    end

    // error flags: a new event wins over a clear
    if (clearErrors || fullReinit) begin
      d.satErr = 1'b0;
      d.ocErr = 1'b0;
      d.toErr = 1'b0;
      d.notifyC = 1'b0;
    end
    if (satFault) begin
      d.satErr = 1'b1; // RL6 RL22
    end
    if (ocFault) begin
      d.ocErr = 1'b1; // RL19 RL22
    end
    if (wdogOver && q.selMirror) begin
      d.toErr = 1'b1; // RL18 RL3
    end
    if (catCEvent) begin
      d.notifyC = 1'b1; // RL3
    end

    // disable states
    if (fastReactivate) begin
      d.disA = 1'b0; // RL1
    end
    if (fullReinit) begin
      d.disA = 1'b0;
      d.disB = 1'b0; // RL2
    end
    if (satFault || ocFault) begin
      d.disA = 1'b1; // RL1
    end
    if (catBEvent) begin
      d.disB = 1'b1; // RL2
    end

    // output stage sequencer
    unique case (q.st)
      ST_OFF: begin
        d.safeOff = 1'b0;
        if (onCmd) begin
          d.st = ST_BLANK;
          d.cnt = `DSBP_RST_CNT;
          d.ocCnt = `DSBP_RST_CNT;
        end
      end
      ST_BLANK: begin
        if (q.ocCnt != 8'hff) begin
          d.ocCnt = q.ocCnt + 8'h01;
        end
        if (ocFault) begin
          d.st = ST_PLAT; // RL10
          d.cnt = `DSBP_RST_CNT;
          d.safeOff = 1'b1;
        end else if (!onCmd) begin
          d.st = ST_ACLD;
          d.cnt = `DSBP_RST_CNT;
        end else if (reached(q.cnt, blankActive)) begin
          d.st = ST_ON; // RL5
        end
      end
      ST_ON: begin
        if (q.ocCnt != 8'hff) begin
          d.ocCnt = q.ocCnt + 8'h01;
        end
        if (satFault || ocFault) begin
          d.st = ST_PLAT; // RL10
          d.cnt = `DSBP_RST_CNT;
          d.safeOff = 1'b1;
        end else if (!onCmd) begin
          d.st = ST_ACLD;
          d.cnt = `DSBP_RST_CNT;
        end
      end
      ST_ACLD: begin
        if (reached(q.cnt, 8'(`DSBP_ACLD_CYC))) begin
          d.st = ST_PLAT;
          d.cnt = `DSBP_RST_CNT;
        end
      end
      ST_PLAT: begin
        if (reached(q.cnt, twoLevelTurnoffTime)) begin
          d.cnt = `DSBP_RST_CNT;
          d.st = (blankActive < `DSBP_EXT_LIMIT) ? ST_HARD : ST_OFF; // RL8
        end
      end
      ST_HARD: begin
        if (reached(q.cnt, blankActive)) begin
          d.st = ST_OFF; // RL8
        end
      end
      default: begin
        d.st = ST_OFF;
      end
    endcase
  end

  // ==========================================================
  // state register
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      q <= '{st: ST_OFF, cnt: `DSBP_RST_CNT, ocCnt: `DSBP_RST_CNT, wdog: `DSBP_RST_WDOG,
             default: '0};
    end else begin
      q <= d;
    end
  end

  // ==========================================================
  // outputs
  assign gateOn = (q.st == ST_BLANK) | (q.st == ST_ON);
  assign twoLevelTurnoff = (q.st == ST_PLAT);
  assign activeClampDelay = (q.st == ST_ACLD);
  assign satSenseOut = 1'b0;
  // pulldown during blanking, plateau and extension, clamp while off
  assign satSenseOe = (q.st == ST_BLANK) | (q.st == ST_PLAT) | (q.st == ST_HARD) // RL5 RL8
                      | (turnoffClampEnable & ((q.st == ST_OFF) | (q.st == ST_ACLD))); // RL9
  assign fastFaultOut_n = ~(q.satErr | q.ocErr); // RL6 RL19
  assign satComparatorStatus = satS; // RL4
  assign satErrorFlag = q.satErr;
  assign overcurrentErrorFlag = q.ocErr;
  assign blankTimeoutError = q.toErr;
  assign blankSelectStatus = q.selStatus; // RL12
  assign blankSelectMirrorPrimary = q.selStatus; // RL12
  assign blankSelectMirror = q.selMirror;
  assign blankRefreshMirror = q.refMirror;
  assign notifyFlag = q.notifyC | q.toErr;
  assign deviceDisabled = q.disA | q.disB;

  // ==========================================================
  // assertions
  a_cat_a_hold: assert property (@(posedge clock) disable iff (!reset_n) // RL1
    q.disA && !fastReactivate && !fullReinit |=> q.disA && !gateOn)
    else $error("class A disable left without reactivation");
  a_cat_b_hold: assert property (@(posedge clock) disable iff (!reset_n) // RL2
    q.disB && !fullReinit |=> q.disB ##1 !$rose(gateOn))
    else $error("class B disable left without reinitialisation");
  a_cat_c_quiet: assert property (@(posedge clock) disable iff (!reset_n) // RL3
    catCEvent && !q.disA && !q.disB && !satFault && !ocFault && !catBEvent
    |=> !deviceDisabled && notifyFlag)
    else $error("class C event changed device state");
  a_comp_status: assert property (@(posedge clock) // RL4
    reset_n && $past(reset_n, 2) |-> satComparatorStatus == $past(satSenseIn, 2))
    else $error("comparator status not the synchronised input");
  a_blank_pull: assert property (@(posedge clock) disable iff (!reset_n) // RL5
    $rose(gateOn) |-> satSenseOe && q.st == ST_BLANK)
    else $error("sense pin not held low at turn-on");
  a_sat_fault: assert property (@(posedge clock) disable iff (!reset_n) // RL6
    satFault |=> satErrorFlag && !fastFaultOut_n && q.st == ST_PLAT && q.safeOff)
    else $error("saturation fault reaction missing");
  a_sat_idle: assert property (@(posedge clock) disable iff (!reset_n) // RL7
    $rose(satErrorFlag) |-> $past(q.st) == ST_ON)
    else $error("saturation flagged outside on-phase");
  a_clamp_off: assert property (@(posedge clock) disable iff (!reset_n) // RL9
    turnoffClampEnable && q.st == ST_OFF |-> satSenseOe && !satSenseOut)
    else $error("sense pin not clamped while off");
  a_safe_skip: assert property (@(posedge clock) disable iff (!reset_n) // RL10
    (satFault || ocFault) |=> !activeClampDelay [*2])
    else $error("safe off passed the clamp delay");
  a_sel_set: assert property (@(posedge clock) disable iff (!reset_n) // RL14
    $rose(blankSelectStatus) |-> $past(q.selMirror) && $past(q.refMirror))
    else $error("selection set without select and refresh");
  a_sel_clear: assert property (@(posedge clock) disable iff (!reset_n) // RL15
    !q.selMirror |=> !blankSelectStatus)
    else $error("selection held after select cleared");
  a_wdog_out: assert property (@(posedge clock) disable iff (!reset_n) // RL18
    wdogOver && q.selMirror && !clearErrors |=> !blankSelectStatus && blankTimeoutError)
    else $error("watchdog timeout not handled");
  a_flag_sticky: assert property (@(posedge clock) disable iff (!reset_n) // RL22
    q.ocErr && !clearErrors && !fullReinit |=> overcurrentErrorFlag)
    else $error("overcurrent flag dropped without clear");

  c_sat_trip: cover property (@(posedge clock) disable iff (!reset_n) satFault);
  c_oc_trip: cover property (@(posedge clock) disable iff (!reset_n) ocFault);
  c_ext_off: cover property (@(posedge clock) disable iff (!reset_n) q.st == ST_HARD);
  c_wdog_to: cover property (@(posedge clock) disable iff (!reset_n) wdogOver);

endmodule
